// >>> include/assc_cfg.svh
// Constants for the axis start/stop control block
`ifndef ASSC_CFG_SVH
`define ASSC_CFG_SVH
`define ASSC_ERR_NONE 16'h0000
`define ASSC_ERR_SIM_AXIS 16'h0128
`define ASSC_ERR_JOG_DEC 16'h0142
`define ASSC_ERR_HALT 16'h01e1
`define ASSC_ERR_EXT_UP 16'h01ec
`define ASSC_ERR_EXT_LO 16'h01ed
`define ASSC_ERR_SOFT_UP 16'h01f5
`define ASSC_ERR_SOFT_LO 16'h01f6
`define ASSC_SPD_CHECK_DETECT 1'b1
`define ASSC_POS_MAX 32'h7fffffff
`define ASSC_POS_MIN 32'h80000000
`endif

// >>> include/assc_pkg.sv
// Types for the axis start/stop control block
package assc_pkg;
    typedef enum logic [2:0] {
        ASSC_MODE_IDLE,
        ASSC_MODE_POS,
        ASSC_MODE_SPEED,
        ASSC_MODE_HOME,
        ASSC_MODE_JOG,
        ASSC_MODE_SYNC,
        ASSC_MODE_INCH
    } assc_mode_e;
    typedef enum logic [1:0] {
        ASSC_STOP_NONE,
        ASSC_STOP_DECEL,
        ASSC_STOP_SUDDEN
    } assc_stop_e;
    typedef struct packed {
        logic signed [31:0] cmd_pos;
        logic signed [31:0] soft_upper;
        logic signed [31:0] soft_lower;
        logic spd_limit_check;
        logic dir_fwd;
        logic ext_upper;
        logic ext_lower;
        logic homed;
    } assc_limit_s;
    typedef struct packed {
        logic [8:0] step;
        logic absolute_coordinates;
        logic signed [31:0] target;
        logic signed [31:0] amount;
    } assc_step_s;
endpackage

// >>> rtl/assc_axis_start_stop.sv
// Start coordination and stop arbitration for several axes
`timescale 1ns/10ps
module assc_axis_start_stop
    import assc_pkg::*;
#(
    parameter int NAXES = 2,
    parameter int STEPW = 9
) (
    input wire logic clk,
    input wire logic resetn,
    input wire assc_mode_e [NAXES-1:0] axis_mode,
    input wire assc_limit_s [NAXES-1:0] axis_limit,
    input wire logic [NAXES-1:0] axis_has_error,
    input wire logic [NAXES-1:0] interp_member,
    input wire logic [$clog2(NAXES)-1:0] interp_main,
    input wire logic [NAXES-1:0] decel_cmd,
    input wire logic [NAXES-1:0] internal_decel,
    input wire logic [NAXES-1:0] sudden_halt_command,
    input wire logic [NAXES-1:0] aux_after_mode,
    input wire logic [NAXES-1:0] aux_set,
    input wire logic [NAXES-1:0] aux_clear,
    input wire logic [NAXES-1:0] ramp_done,
    input wire logic [NAXES-1:0] at_target,
    input wire logic [NAXES-1:0] decel_exceeds_remain,
    input wire logic [NAXES-1:0] origin_in,
    input wire logic [NAXES-1:0] near_origin_in,
    input wire logic [NAXES-1:0] indirect_start,
    input wire logic [NAXES-1:0][STEPW-1:0] start_step,
    input wire logic [NAXES-1:0][STEPW-1:0] current_step,
    input wire assc_step_s [NAXES-1:0] step_data,
    input wire logic [NAXES-1:0][31:0] cur_pos,
    input wire logic sim_start,
    input wire logic [$clog2(NAXES)-1:0] sim_cmd_axis,
    input wire logic [NAXES-1:0] sim_axes,
    output logic [NAXES-1:0] start_go,
    output logic [NAXES-1:0][STEPW-1:0] run_step,
    output logic [NAXES-1:0][31:0] run_amount,
    output assc_stop_e [NAXES-1:0] stop_style,
    output logic [NAXES-1:0] speed_zero,
    output logic [NAXES-1:0] pulse_enable,
    output logic [NAXES-1:0] long_decel_ok,
    output logic [NAXES-1:0] target_clamp,
    output logic [NAXES-1:0] stop_status,
    output logic [NAXES-1:0] error_flag,
    output logic [NAXES-1:0][15:0] error_code,
    output logic [NAXES-1:0] aux_code_on,
    output logic [NAXES-1:0] pos_complete,
    output logic [NAXES-1:0] origin_seen
);
`include "assc_cfg.svh"

    initial begin
        if (NAXES < 2) begin
            $error("assc_axis_start_stop needs at least two axes");
        end
        if (STEPW < 1) begin
            $error("assc_axis_start_stop needs a step field of one bit or more");
        end
    end

    // Simultaneous start validity, shared by all axes
    wire [NAXES-1:0] sim_cmd_bit = NAXES'(1) << sim_cmd_axis;
    wire [NAXES-1:0] sim_others = sim_axes & ~sim_cmd_bit;
    wire sim_bad_sel = !sim_axes[sim_cmd_axis] || (sim_others == '0);
    wire sim_any_err = |(sim_axes & axis_has_error);
    wire sim_ok = sim_start && !sim_bad_sel && !sim_any_err;

    wire main_sudden;
    wire main_decel;
    logic [NAXES-1:0] sudden_w;
    logic [NAXES-1:0] decel_w;
    assign main_sudden = sudden_w[interp_main];
    assign main_decel = decel_w[interp_main];

    genvar g;
    generate
        for (g = 0; g < NAXES; g++) begin : g_axis
            logic lim_sudden;
            logic [15:0] lim_code;
            logic signed [31:0] amt;

            logic [STEPW-1:0] step_q;
            logic [STEPW-1:0] step_d;

            logic go_d;
            logic go_q;

            logic [31:0] amt_q;
            logic [31:0] amt_d;

            assc_stop_e style_q;
            assc_stop_e style_d;

            logic stat_q;
            logic stat_d;

            logic err_q;
            logic err_d;

            logic [15:0] code_q;
            logic [15:0] code_d;

            logic aux_q;
            logic aux_d;

            logic cmpl_q;
            logic cmpl_d;

            logic org_q;
            logic org_d;

            logic stopped_short_q;
            logic stopped_short_d;

            assc_limit_check u_lim (
                .lim(axis_limit[g]),
                .mode(axis_mode[g]),
                .sudden(lim_sudden),
                .err_code(lim_code)
            );
            assc_restart_calc u_rst (
                .step_data(step_data[g]),
                .cur_pos(cur_pos[g]),
                .move_amount(amt)
            );

            wire moving = axis_mode[g] != ASSC_MODE_IDLE;
            wire in_interp = interp_member[g] && (g != interp_main);
            wire halt = moving && sudden_halt_command[g];
            wire jog = axis_mode[g] == ASSC_MODE_JOG;
            wire jog_decel = decel_cmd[g] && jog;
            // Decel command acts the same regardless of ramp phase
            wire own_decel = moving && !jog && (decel_cmd[g] || internal_decel[g]);
            wire do_sudden = halt || lim_sudden || (in_interp && main_sudden);
            wire do_decel = own_decel || (in_interp && main_decel);
            assign sudden_w[g] = do_sudden;
            assign decel_w[g] = do_decel;

            wire sel_start = indirect_start[g] || (sim_ok && sim_axes[g]);
            wire [STEPW-1:0] eff_step = (start_step[g] == '0) ? current_step[g] : start_step[g];
            wire same_step = eff_step == current_step[g];
            wire [31:0] restart_amt = (stopped_short_q && same_step) ? amt : step_data[g].amount;
            assign go_d = sel_start && !axis_has_error[g] && !err_q;
            assign step_d = go_d ? eff_step : step_q;
            assign amt_d = go_d ? restart_amt : amt_q;

            // Sudden wins over decel, every cycle per axis
            wire ramp_end = style_q == ASSC_STOP_DECEL && ramp_done[g];
            assign style_d = do_sudden ? ASSC_STOP_SUDDEN :
                             do_decel ? ASSC_STOP_DECEL :
                             (go_d || ramp_end) ? ASSC_STOP_NONE : style_q;
            assign stat_d = ramp_end || (halt && !err_q) ? 1'b1 :
                            (go_d ? 1'b0 : stat_q);

            wire sim_err_here = sim_start && sim_axes[g] && axis_has_error[g];
            wire sim_bad_here = sim_start && sim_bad_sel && (g == sim_cmd_axis);
            wire err_cause = halt || lim_sudden || jog_decel || sim_bad_here || sim_err_here;
            assign err_d = err_cause || err_q;
            assign code_d = halt ? `ASSC_ERR_HALT :
                            lim_sudden ? lim_code :
                            jog_decel ? `ASSC_ERR_JOG_DEC :
                            sim_bad_here ? `ASSC_ERR_SIM_AXIS : code_q;

            wire short_stop = ramp_end && !at_target[g];
            assign stopped_short_d = short_stop ? 1'b1 : (go_q ? 1'b0 : stopped_short_q);
            // Halt clears aux; after-mode aux never set on short stop
            wire aux_block = aux_after_mode[g] && (stopped_short_q || short_stop);
            assign aux_d = halt ? 1'b0 :
                           (aux_set[g] && !aux_block) ? 1'b1 :
                           (aux_clear[g] ? 1'b0 : aux_q);
            wire cmpl_hit = at_target[g] && !stopped_short_q && !short_stop;
            assign cmpl_d = go_d ? 1'b0 : (cmpl_hit ? 1'b1 : cmpl_q);
            assign org_d = axis_limit[g].homed ? 1'b0 : (origin_in[g] || near_origin_in[g]);

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    step_q <= '0;
                end else begin
                    step_q <= step_d;
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    amt_q <= '0;
                end else begin
                    amt_q <= amt_d;
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    go_q <= 1'b0;
                end else begin
                    go_q <= go_d;
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    style_q <= ASSC_STOP_NONE;
                end else begin
                    style_q <= style_d;
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    stat_q <= 1'b0;
                end else begin
                    stat_q <= stat_d;
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    err_q <= 1'b0;
                end else begin
                    err_q <= err_d;
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    code_q <= `ASSC_ERR_NONE;
                end else begin
                    code_q <= code_d;
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    aux_q <= 1'b0;
                end else begin
                    aux_q <= aux_d;
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    cmpl_q <= 1'b0;
                end else begin
                    cmpl_q <= cmpl_d;
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    stopped_short_q <= 1'b0;
                end else begin
                    stopped_short_q <= stopped_short_d;
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    org_q <= 1'b0;
                end else begin
                    org_q <= org_d;
                end
            end

            assign start_go[g] = go_q;
            assign run_step[g] = step_q;
            assign run_amount[g] = amt_q;

            assign stop_style[g] = style_q;
            assign speed_zero[g] = style_q == ASSC_STOP_SUDDEN;
            assign pulse_enable[g] = moving && style_q != ASSC_STOP_SUDDEN;
            assign long_decel_ok[g] = internal_decel[g] && style_q == ASSC_STOP_DECEL;
            assign target_clamp[g] = style_q == ASSC_STOP_DECEL && decel_exceeds_remain[g] &&
                                     axis_mode[g] == ASSC_MODE_POS;

            assign stop_status[g] = stat_q;
            assign error_flag[g] = err_q;
            assign error_code[g] = code_q;
            assign aux_code_on[g] = aux_q;
            assign pos_complete[g] = cmpl_q;
            assign origin_seen[g] = org_q;
        end
    endgenerate
endmodule

// >>> rtl/assc_limit_check.sv
// Per-axis limit checker for soft and external stroke limits
`timescale 1ns/10ps
module assc_limit_check
    import assc_pkg::*;
(
    input wire assc_limit_s lim,
    input wire assc_mode_e mode,
    output logic sudden,
    output logic [15:0] err_code
);
`include "assc_cfg.svh"
    wire soft_off = (lim.soft_upper == lim.soft_lower) ||
        (lim.soft_upper == $signed(`ASSC_POS_MAX) && lim.soft_lower == $signed(`ASSC_POS_MIN));
    // Speed control only checks when detection is enabled
    wire soft_en = !soft_off && (mode != ASSC_MODE_HOME) && (mode != ASSC_MODE_IDLE) &&
        ((mode != ASSC_MODE_SPEED) || (lim.spd_limit_check == `ASSC_SPD_CHECK_DETECT));
    wire soft_up = soft_en && (lim.cmd_pos > lim.soft_upper);
    wire soft_lo = soft_en && (lim.cmd_pos < lim.soft_lower);
    wire moving = mode != ASSC_MODE_IDLE;
    // Jog stops only when heading into the active limit
    wire ext_up = moving && lim.ext_upper && ((mode != ASSC_MODE_JOG) || lim.dir_fwd);
    wire ext_lo = moving && lim.ext_lower && ((mode != ASSC_MODE_JOG) || !lim.dir_fwd);
    assign sudden = soft_up || soft_lo || ext_up || ext_lo;
    assign err_code = ext_up ? `ASSC_ERR_EXT_UP :
                      ext_lo ? `ASSC_ERR_EXT_LO :
                      soft_up ? `ASSC_ERR_SOFT_UP :
                      soft_lo ? `ASSC_ERR_SOFT_LO : `ASSC_ERR_NONE;
endmodule

// >>> rtl/assc_restart_calc.sv
// Restart distance selection after a deceleration stop
`timescale 1ns/10ps
module assc_restart_calc
    import assc_pkg::*;
(
    input wire assc_step_s step_data,
    input wire logic signed [31:0] cur_pos,
    output logic signed [31:0] move_amount
);
    wire signed [31:0] remain = step_data.target - cur_pos;
    assign move_amount = step_data.absolute_coordinates ? remain : step_data.amount;
endmodule

// >>> sim/assc_axis_start_stop_sva.sv
// Concurrent checks on the axis start/stop block ports
`timescale 1ns/10ps
module assc_axis_start_stop_sva
    import assc_pkg::*;
#(
    parameter int NAXES = 2
) (
    input wire logic clk,
    input wire logic resetn,
    input wire assc_mode_e [NAXES-1:0] axis_mode,
    input wire assc_limit_s [NAXES-1:0] axis_limit,
    input wire logic [NAXES-1:0] axis_has_error,
    input wire logic [NAXES-1:0] interp_member,
    input wire logic [$clog2(NAXES)-1:0] interp_main,
    input wire logic [NAXES-1:0] decel_cmd,
    input wire logic [NAXES-1:0] sudden_halt_command,
    input wire logic sim_start,
    input wire logic [NAXES-1:0] sim_axes,
    input wire logic [NAXES-1:0] start_go,
    input wire assc_stop_e [NAXES-1:0] stop_style,
    input wire logic [NAXES-1:0][15:0] error_code,
    input wire logic [NAXES-1:0] aux_code_on
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire logic run0 = axis_mode[0] != ASSC_MODE_IDLE;
    wire logic calm0 = !sudden_halt_command[0] && !axis_limit[0].ext_upper && !axis_limit[0].ext_lower;
    chk_halt_code: assert property (
        sudden_halt_command[0] && run0 |=> stop_style[0] == ASSC_STOP_SUDDEN && error_code[0] == 16'h01e1)
        else $error("halt did not stop axis with its code");
    chk_halt_aux: assert property (
        sudden_halt_command[0] && run0 |=> !aux_code_on[0]) else $error("aux code still on after halt");
    chk_sim_lone: assert property (
        sim_start && $countones(sim_axes) < 2 |=> start_go == '0) else $error("lone axis start accepted");
    chk_sim_fault: assert property (
        sim_start && (sim_axes & axis_has_error) != '0 |=> (start_go & sim_axes) == '0)
        else $error("start went ahead with a faulty axis");
    chk_decel_pos: assert property (
        decel_cmd[0] && axis_mode[0] == ASSC_MODE_POS && calm0 && stop_style[0] != ASSC_STOP_SUDDEN
        |=> stop_style[0] == ASSC_STOP_DECEL) else $error("decel command not applied");
    chk_jog_decel: assert property (
        decel_cmd[0] && axis_mode[0] == ASSC_MODE_JOG && calm0
        |=> error_code[0] == 16'h0142 && stop_style[0] != ASSC_STOP_DECEL) else $error("jog decel mishandled");
    chk_ext_upper: assert property (
        axis_limit[0].ext_upper && axis_mode[0] == ASSC_MODE_POS && !sudden_halt_command[0]
        |=> stop_style[0] == ASSC_STOP_SUDDEN && error_code[0] == 16'h01ec) else $error("upper stroke missed");
    chk_sudden_wins: assert property (
        stop_style[0] == ASSC_STOP_DECEL && run0 && (sudden_halt_command[0] || axis_limit[0].ext_upper)
        |=> stop_style[0] == ASSC_STOP_SUDDEN) else $error("ramp kept despite sudden cause");
    chk_interp_grp: assert property (
        interp_member[0] && interp_member[1] && interp_main == '0 && sudden_halt_command[0] && run0
        && axis_mode[1] != ASSC_MODE_IDLE |=> stop_style[1] != ASSC_STOP_NONE) else $error("group member ran on");
endmodule
bind assc_axis_start_stop assc_axis_start_stop_sva #(.NAXES(NAXES)) u_sva (.*);

// >>> sim/assc_axis_start_stop_tb.sv
// Self-checking bench for the axis start/stop block
`timescale 1ns/10ps
module assc_axis_start_stop_tb
    import assc_pkg::*;
;
    logic clk, resetn, sim_start;
    assc_mode_e [1:0] axis_mode;
    assc_limit_s [1:0] axis_limit;
    assc_step_s [1:0] step_data;
    assc_stop_e [1:0] stop_style;
    logic [1:0] axis_has_error, interp_member, internal_decel, aux_after_mode, aux_set, aux_clear, ramp_done;
    logic [1:0] at_target, decel_exceeds_remain, origin_in, near_origin_in, indirect_start, sim_axes, decel_cmd;
    logic [1:0] sudden_halt_command, start_go, speed_zero, pulse_enable, long_decel_ok, target_clamp;
    logic [1:0] stop_status, error_flag, aux_code_on, pos_complete, origin_seen;
    logic [0:0] interp_main, sim_cmd_axis;
    logic [1:0][8:0] start_step, current_step, run_step;
    logic [1:0][31:0] cur_pos, run_amount;
    logic [1:0][15:0] error_code;
    int fails = 0, n_checks = 0, cyc = 0;
    assc_axis_start_stop #(.NAXES(2), .STEPW(9)) u_dut (.*);
    assc_host u_host (.clk(clk), .sim_start(sim_start), .sim_cmd_axis(sim_cmd_axis), .sim_axes(sim_axes),
        .decel_cmd(decel_cmd), .sudden_halt_command(sudden_halt_command));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic end_sim();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            end_sim();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask
    task automatic idle();
        resetn <= 1'b0;
        axis_mode[0] <= ASSC_MODE_IDLE;
        axis_mode[1] <= ASSC_MODE_IDLE;
        {axis_limit, axis_has_error, interp_member, interp_main, internal_decel, aux_after_mode, aux_set, aux_clear,
            ramp_done, at_target, decel_exceeds_remain, origin_in, near_origin_in, indirect_start, start_step,
            current_step, step_data, cur_pos} <= '0;
    endtask
    task automatic rst(input int n);
        @(posedge clk);
        idle();
        repeat (n) @(posedge clk);
        resetn <= 1'b1;
    endtask
    task automatic look();
        @(posedge clk);
        #1;
    endtask
    task automatic lim(input assc_mode_e m, input logic [31:0] p, input logic c, input logic l, input logic f,
        input logic [15:0] e, input string w);
        rst(2);
        axis_mode[0] <= m;
        axis_limit[0].cmd_pos <= p;
        axis_limit[0].soft_upper <= 32'h00000064;
        axis_limit[0].soft_lower <= 32'hffffff9c;
        axis_limit[0].spd_limit_check <= c;
        axis_limit[0].ext_lower <= l;
        axis_limit[0].dir_fwd <= f;
        look();
        check(error_code[0], e, w);
        check(speed_zero[0], e != 16'h0000, w);
        $display("test %s done", w);
    endtask
    initial begin
        idle();
        rst(8);
        @(posedge clk);
        current_step[0] <= 9'h005;
        indirect_start[0] <= 1'b1;
        @(posedge clk);
        indirect_start[0] <= 1'b0;
        #1;
        check(start_go[0], 1'b1, "step zero start");
        check(run_step[0], 9'h005, "step zero step");
        u_host.sim_go(2'b11);
        #1;
        check(start_go, 2'b11, "sim start both");
        u_host.sim_go(2'b01);
        #1;
        check(start_go, 2'b00, "lone axis start");
        check(error_code[0], 16'h0128, "bad selection code");
        rst(2);
        axis_has_error[1] <= 1'b1;
        u_host.sim_go(2'b11);
        #1;
        check(start_go, 2'b00, "faulty axis blocks");
        $display("test starts done");
        rst(2);
        axis_mode[0] <= ASSC_MODE_POS;
        aux_set[0] <= 1'b1;
        look();
        aux_set[0] <= 1'b0;
        check(aux_code_on[0], 1'b1, "aux set");
        u_host.cmd(2'b00, 2'b01);
        #1;
        check(stop_style[0], ASSC_STOP_SUDDEN, "halt style");
        check(pulse_enable[0], 1'b0, "halt output");
        check(error_code[0], 16'h01e1, "halt code");
        check(aux_code_on[0], 1'b0, "halt aux");
        check(speed_zero[0], 1'b1, "halt speed");
        check(error_flag[0], 1'b1, "halt error flag");
        rst(2);
        axis_mode <= {ASSC_MODE_POS, ASSC_MODE_POS};
        interp_member <= 2'b11;
        u_host.cmd(2'b00, 2'b01);
        #1;
        check(stop_style[1] === ASSC_STOP_NONE, 1'b0, "group member");
        $display("test halt done");
        rst(2);
        axis_mode[0] <= ASSC_MODE_POS;
        u_host.cmd(2'b01, 2'b00);
        #1;
        check(stop_style[0], ASSC_STOP_DECEL, "decel style");
        check(pos_complete[0], 1'b0, "decel no complete");
        @(posedge clk);
        axis_limit[0].ext_upper <= 1'b1;
        look();
        check(stop_style[0], ASSC_STOP_SUDDEN, "limit beats decel");
        check(error_code[0], 16'h01ec, "upper stroke code");
        rst(2);
        axis_mode[0] <= ASSC_MODE_JOG;
        u_host.cmd(2'b01, 2'b00);
        #1;
        check(error_code[0], 16'h0142, "jog decel code");
        check(stop_style[0] === ASSC_STOP_DECEL, 1'b0, "jog goes on");
        $display("test decel done");
        lim(ASSC_MODE_POS, 32'h000000c8, 1'b0, 1'b0, 1'b1, 16'h01f5, "soft upper");
        lim(ASSC_MODE_POS, 32'hffffff38, 1'b0, 1'b0, 1'b1, 16'h01f6, "soft lower");
        lim(ASSC_MODE_HOME, 32'h000000c8, 1'b0, 1'b0, 1'b1, 16'h0000, "homing unchecked");
        lim(ASSC_MODE_SPEED, 32'h000000c8, 1'b0, 1'b0, 1'b1, 16'h0000, "speed unchecked");
        lim(ASSC_MODE_SPEED, 32'h000000c8, 1'b1, 1'b0, 1'b1, 16'h01f5, "speed checked");
        lim(ASSC_MODE_POS, 32'h00000000, 1'b0, 1'b1, 1'b1, 16'h01ed, "lower stroke");
        lim(ASSC_MODE_JOG, 32'h00000000, 1'b0, 1'b1, 1'b1, 16'h0000, "jog away");
        lim(ASSC_MODE_JOG, 32'h00000000, 1'b0, 1'b1, 1'b0, 16'h01ed, "jog toward");
        rst(2);
        axis_mode[0] <= ASSC_MODE_POS;
        internal_decel[0] <= 1'b1;
        decel_exceeds_remain[0] <= 1'b1;
        look();
        check(long_decel_ok[0], 1'b1, "internal decel ramp");
        check(target_clamp[0], 1'b1, "stop at target");
        rst(2);
        axis_mode[0] <= ASSC_MODE_POS;
        at_target[0] <= 1'b1;
        origin_in[0] <= 1'b1;
        look();
        check(pos_complete[0], 1'b1, "complete at target");
        check(origin_seen[0], 1'b1, "origin before homing");
        @(posedge clk);
        axis_limit[0].homed <= 1'b1;
        look();
        check(origin_seen[0], 1'b0, "origin after homing");
        $display("test ramp and origin done");
        for (int a = 0; a < 2; a++) begin
            rst(2);
            axis_mode[0] <= ASSC_MODE_POS;
            current_step[0] <= 9'h003;
            start_step[0] <= 9'h003;
            step_data[0] <= '{9'h003, a[0], 32'h000003e8, 32'h000002bc};
            cur_pos[0] <= 32'h00000190;
            u_host.cmd(2'b01, 2'b00);
            ramp_done[0] <= 1'b1;
            look();
            check(stop_status[0], 1'b1, "stop status");
            @(posedge clk);
            indirect_start[0] <= 1'b1;
            aux_after_mode[0] <= 1'b1;
            aux_set[0] <= 1'b1;
            @(posedge clk);
            indirect_start[0] <= 1'b0;
            #1;
            check(run_amount[0], a ? 32'h00000258 : 32'h000002bc, "restart amount");
            check(aux_code_on[0], 1'b0, "after-mode aux held off");
        end
        $display("test restart done");
        end_sim();
    end
endmodule

// >>> sim/assc_host.sv
// Host processor model issuing start and stop commands
`timescale 1ns/10ps
module assc_host (
    input wire logic clk,
    output logic sim_start,
    output logic [0:0] sim_cmd_axis,
    output logic [1:0] sim_axes,
    output logic [1:0] decel_cmd,
    output logic [1:0] sudden_halt_command
);
    initial begin
        {sim_start, sim_cmd_axis, sim_axes, decel_cmd, sudden_halt_command} = '0;
    end
    // Axis 0 commands; a lone axis is sent only when a refusal is wanted
    task automatic sim_go(input logic [1:0] axes);
        @(posedge clk);
        sim_axes <= axes;
        sim_start <= 1'b1;
        @(posedge clk);
        sim_start <= 1'b0;
    endtask
    // Jog is ended by leaving jog mode, a decel pulse in jog only probes the refusal
    task automatic cmd(input logic [1:0] dec, input logic [1:0] halt);
        @(posedge clk);
        decel_cmd <= dec;
        sudden_halt_command <= halt;
        @(posedge clk);
        decel_cmd <= 2'b00;
        sudden_halt_command <= 2'b00;
    endtask
endmodule
